// File: verilog/autoneg_page_pkg.sv
package autoneg_page_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [4:0] partner_ability_addr = 5'h05;
    localparam logic [4:0] negotiation_expansion_addr = 5'h06;
    localparam logic [4:0] local_next_page_addr = 5'h07;
    localparam logic [4:0] partner_next_page_addr = 5'h08;
    localparam logic [4:0] digital_control_addr = 5'h10;
    localparam logic [4:0] analog_frontend_control_addr = 5'h11;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int next_page_bit = 15;
    localparam int ack_bit = 14;
    localparam int remote_fault_bit = 13;
    localparam int message_page_bit = 13;
    localparam int comply_bit = 12;
    localparam int toggle_bit = 11;
    localparam int pll_off_bit = 4;

    // ****************************************
    // Reset values and write masks
    // ****************************************
    localparam logic [15:0] partner_ability_reset = 16'h0001;
    localparam logic [4:0] selector_reset = 5'h01;
    localparam logic [10:0] local_message_reset = 11'h001;
    localparam logic local_message_page_reset = 1'b1;
    localparam logic local_np_able_reset = 1'b1;
    localparam logic [15:0] digital_control_reset = 16'h0000;
    localparam logic [15:0] analog_control_reset = 16'h0000;
    localparam logic [15:0] digital_control_wmask = 16'hFFFF;
    localparam logic [15:0] analog_control_wmask = 16'hFFC0;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic next_page;
        logic ack;
        logic remote_fault;
        logic [1:0] pause;
        logic t4;
        logic tx_full;
        logic tx_half;
        logic t_full;
        logic t_half;
        logic [4:0] selector;
    } base_page_type;

    typedef struct packed {
        logic more_pages;
        logic ack;
        logic message_page;
        logic message_comply_flag;
        logic toggle;
        logic [10:0] message;
    } next_page_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_type;

endpackage

// File: verilog/autoneg_page_registers.sv
`timescale 1ns/1ps

module autoneg_page_registers
    import autoneg_page_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire mgmt_req_type mgmt_req_i,
    output logic [15:0] mgmt_rdata_o,
    input wire logic base_page_valid_i,
    input wire base_page_type base_page_i,
    input wire logic partner_an_able_i,
    input wire logic next_page_valid_i,
    input wire next_page_type next_page_i,
    input wire logic page_received_i,
    input wire logic parallel_fault_i,
    input wire logic page_sent_i,
    input wire logic energy_detect_powerdown_i,
    output next_page_type local_page_o,
    output logic pll_enable_o
);

    // ****************************************
    // Helpers
    // ****************************************
    // One address compare shared by every register decode
    function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] offset);
        return addr == offset;
    endfunction

    // Latching-high update; the set wins so an event in the read cycle survives
    function automatic logic latch_next(input logic held, input logic set_in,
        input logic clear_in);
        return set_in || (held && !clear_in);
    endfunction

    // Partner reset image without the reserved bit 12
    localparam base_page_type partner_base_reset =
        {partner_ability_reset[15:13], partner_ability_reset[11:0]};

    // ****************************************
    // State
    // ****************************************
    // Partner side, captured from the exchange
    base_page_type partner_base;
    next_page_type partner_np;
    logic partner_able;
    // Latching status flags
    logic fault_latch;
    logic page_latch;
    // Local next page fields, software owned apart from the toggle
    logic local_more_pages;
    logic local_message_page;
    logic local_message_comply_flag;
    logic [10:0] local_message;
    logic local_toggle;
    // Toggle history of the last sent word and its partner-side inverse
    logic sent_toggle;
    logic partner_toggle;
    // Control registers
    logic [15:0] digital_control;
    logic [15:0] analog_control;

    // ****************************************
    // Decode
    // ****************************************
    // Register selects from the management address
    wire logic hit_ability = addr_hit(mgmt_req_i.addr, partner_ability_addr);
    wire logic hit_expansion = addr_hit(mgmt_req_i.addr, negotiation_expansion_addr);
    wire logic hit_local = addr_hit(mgmt_req_i.addr, local_next_page_addr);
    wire logic hit_partner_np = addr_hit(mgmt_req_i.addr, partner_next_page_addr);
    wire logic hit_digital = addr_hit(mgmt_req_i.addr, digital_control_addr);
    wire logic hit_analog = addr_hit(mgmt_req_i.addr, analog_frontend_control_addr);
    // Qualified strobes
    wire logic read_expansion = mgmt_req_i.read && hit_expansion;
    wire logic write_local = mgmt_req_i.write && hit_local;
    wire logic write_digital = mgmt_req_i.write && hit_digital;
    wire logic write_analog = mgmt_req_i.write && hit_analog;

    // ****************************************
    // Next values
    // ****************************************
    // Latch updates; only a read of the expansion register clears them
    wire logic next_fault_latch =
        latch_next(fault_latch, parallel_fault_i, read_expansion);
    wire logic next_page_latch =
        latch_next(page_latch, page_received_i, read_expansion);
    // Written control words lose their read-only bits here
    wire logic [15:0] next_digital = mgmt_req_i.wdata & digital_control_wmask;
    wire logic [15:0] next_analog = mgmt_req_i.wdata & analog_control_wmask;

    // ****************************************
    // Read images
    // ****************************************
    // Reserved positions are tied low so they always read zero
    wire logic [15:0] ability_image = {partner_base.next_page, partner_base.ack,
        partner_base.remote_fault, 1'b0, partner_base.pause, partner_base.t4,
        partner_base.tx_full, partner_base.tx_half, partner_base.t_full,
        partner_base.t_half, partner_base.selector};
    wire logic [15:0] expansion_image = {11'h000, fault_latch,
        partner_base.next_page, local_np_able_reset, page_latch,
        partner_able};
    wire logic [15:0] local_image = {local_more_pages, 1'b0,
        local_message_page, local_message_comply_flag, sent_toggle,
        local_message};
    wire logic [15:0] partner_np_image = {partner_np.more_pages, partner_np.ack,
        partner_np.message_page, partner_np.message_comply_flag, partner_toggle,
        partner_np.message};

    // Unmapped offsets fall through to zero
    wire logic [15:0] next_rdata =
        hit_ability ? ability_image :
        hit_expansion ? expansion_image :
        hit_local ? local_image :
        hit_partner_np ? partner_np_image :
        hit_digital ? digital_control :
        hit_analog ? analog_control : 16'h0000;

    // ****************************************
    // Partner capture
    // ****************************************
    // Words are taken as complete; the exchange has already checked them,
    // so a valid pulse with a damaged word would be stored as it stands
    // Base page, loaded on each received base word
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            partner_base <= partner_base_reset;
        end else if (base_page_valid_i) begin
            partner_base <= base_page_i;
        end
    end

    // Auto-negotiation ability travels with the base word
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            partner_able <= 1'b0;
        end else if (base_page_valid_i) begin
            partner_able <= partner_an_able_i;
        end
    end

    // Partner next page; its own toggle is not shown, see the history below
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            partner_np <= '0;
        end else if (next_page_valid_i) begin
            partner_np <= next_page_i;
        end
    end

    // ****************************************
    // Status latches
    // ****************************************
    // Parallel detection fault, held until software reads it
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            fault_latch <= 1'b0;
        end else begin
            fault_latch <= next_fault_latch;
        end
    end

    // Page received, held until software reads it
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            page_latch <= 1'b0;
        end else begin
            page_latch <= next_page_latch;
        end
    end

    // ****************************************
    // Local next page
    // ****************************************
    // More-pages bit, written by software for each page
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            local_more_pages <= 1'b0;
        end else if (write_local) begin
            local_more_pages <= mgmt_req_i.wdata[next_page_bit];
        end
    end

    // Message or unformatted page
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            local_message_page <= local_message_page_reset;
        end else if (write_local) begin
            local_message_page <= mgmt_req_i.wdata[message_page_bit];
        end
    end

    // Will-comply flag sent with the page
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            local_message_comply_flag <= 1'b0;
        end else if (write_local) begin
            local_message_comply_flag <= mgmt_req_i.wdata[comply_bit];
        end
    end

    // Message field; a new write before the send replaces the old one
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            local_message <= local_message_reset;
        end else if (write_local) begin
            local_message <= mgmt_req_i.wdata[10:0];
        end
    end

    // Toggle flips after every sent word; software cannot touch it
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            local_toggle <= 1'b0;
        end else if (page_sent_i) begin
            local_toggle <= ~local_toggle;
        end
    end

    // Toggle value of the word just sent
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sent_toggle <= 1'b0;
        end else if (page_sent_i) begin
            sent_toggle <= local_toggle;
        end
    end

    // Inverse history; reads zero until a first word has gone out
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            partner_toggle <= 1'b0;
        end else if (page_sent_i) begin
            partner_toggle <= ~local_toggle;
        end
    end

    // ****************************************
    // Control and read data
    // ****************************************
    // Digital control, fully writable
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            digital_control <= digital_control_reset;
        end else if (write_digital) begin
            digital_control <= next_digital;
        end
    end

    // Analog control; only the upper field is kept
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            analog_control <= analog_control_reset;
        end else if (write_analog) begin
            analog_control <= next_analog;
        end
    end

    // Read data captured at the read edge, held until the next read
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            mgmt_rdata_o <= 16'h0000;
        end else if (mgmt_req_i.read) begin
            mgmt_rdata_o <= next_rdata;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // PLL stops only when allowed and power-down is active
    assign pll_enable_o = !(digital_control[pll_off_bit] && energy_detect_powerdown_i);
    // Page handed to the transmitter; acknowledge is added downstream
    assign local_page_o = '{
        more_pages: local_more_pages,
        ack: 1'b0,
        message_page: local_message_page,
        message_comply_flag: local_message_comply_flag,
        toggle: local_toggle,
        message: local_message
    };

endmodule

// File: bench/autoneg_page_properties.sv
`timescale 1ns/1ps
// ********
// Port checks
// ********
module autoneg_page_properties
    import autoneg_page_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire mgmt_req_type mgmt_req_i,
    input wire logic [15:0] mgmt_rdata_o,
    input wire logic base_page_valid_i,
    input wire base_page_type base_page_i,
    input wire logic page_received_i,
    input wire logic page_sent_i,
    input wire next_page_type local_page_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // Decodes; unmapped offsets must read empty
    wire rd5 = mgmt_req_i.read && mgmt_req_i.addr == 5'h05;
    wire rd6 = mgmt_req_i.read && mgmt_req_i.addr == 5'h06;
    wire wr7 = mgmt_req_i.write && mgmt_req_i.addr == 5'h07;
    wire hole = !(mgmt_req_i.addr inside {[5'h05:5'h08], 5'h10, 5'h11});
    sequence base_then_read;
        base_page_valid_i ##1 rd5 && !base_page_valid_i;
    endsequence
    sequence read_gap_read;
        rd6 && !page_received_i ##1 !page_received_i ##1 rd6;
    endsequence
    base_image_a: assert property (base_then_read |=>
        mgmt_rdata_o == {$past(base_page_i[14:12], 2), 1'b0, $past(base_page_i[11:0], 2)})
        else $error("ability image wrong");
    page_flag_a: assert property (page_received_i ##1 rd6 |=> mgmt_rdata_o[1])
        else $error("page flag lost");
    flag_clear_a: assert property (read_gap_read |=> !mgmt_rdata_o[1])
        else $error("page flag stuck");
    expansion_fixed_a: assert property (rd6 |=>
        mgmt_rdata_o[15:5] == 11'h000 && mgmt_rdata_o[2])
        else $error("expansion fixed bits wrong");
    hole_zero_a: assert property (mgmt_req_i.read && hole |=> mgmt_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    data_hold_a: assert property (!mgmt_req_i.read |=> $stable(mgmt_rdata_o))
        else $error("read data moved");
    toggle_flip_a: assert property (page_sent_i |=>
        local_page_o.toggle != $past(local_page_o.toggle))
        else $error("toggle not flipped");
    local_write_a: assert property (wr7 |=>
        (local_page_o & 16'hB7FF) == ($past(mgmt_req_i.wdata) & 16'hB7FF))
        else $error("local page write lost");
endmodule

bind autoneg_page_registers autoneg_page_properties u_props (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .mgmt_req_i(mgmt_req_i), .mgmt_rdata_o(mgmt_rdata_o),
    .base_page_valid_i(base_page_valid_i), .base_page_i(base_page_i),
    .page_received_i(page_received_i), .page_sent_i(page_sent_i), .local_page_o(local_page_o));

// File: bench/an_partner.sv
`timescale 1ns/1ps
// ********
// Remote partner
// ********
module an_partner
    import autoneg_page_pkg::*;
(
    input wire logic core_clk_i,
    output logic base_valid_o,
    output base_page_type base_o,
    output logic able_o,
    output logic next_valid_o,
    output next_page_type next_o,
    output logic rx_o
);
    // Quiet lines at start
    initial {base_valid_o, next_valid_o, rx_o, base_o, able_o, next_o} = '0;
    // Data flips after the pulse so a stale word never looks fresh
    task automatic send(input base_page_type b, input logic a, input next_page_type n);
        {base_o, able_o, next_o} = {b, a, n};
        {base_valid_o, next_valid_o, rx_o} = 3'h7;
        @(posedge core_clk_i);
        #1;
        {base_o, able_o, next_o} = ~{b, a, n};
        {base_valid_o, next_valid_o, rx_o} = 3'h0;
    endtask
endmodule

// File: bench/autoneg_page_registers_test.sv
`timescale 1ns/1ps
// ********
// Register bank bench
// ********
module autoneg_page_registers_test
    import autoneg_page_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic sent = 1'b0;
    logic pd = 1'b0;
    logic fault = 1'b0;
    logic bv, nv, pr, able, pll;
    logic [15:0] rdata, got;
    mgmt_req_type req = '0;
    base_page_type bp;
    next_page_type np, lp;
    int fails = 0, n_checks = 0, cycles = 0;
    // Clock and a ceiling well past the roughly 94 cycles needed
    initial forever #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            stop_test;
        end
    end
    autoneg_page_registers u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .mgmt_req_i(req), .mgmt_rdata_o(rdata), .base_page_valid_i(bv), .base_page_i(bp),
        .partner_an_able_i(able), .next_page_valid_i(nv), .next_page_i(np),
        .page_received_i(pr), .parallel_fault_i(fault), .page_sent_i(sent),
        .energy_detect_powerdown_i(pd), .local_page_o(lp), .pll_enable_o(pll));
    an_partner u_partner (.core_clk_i(core_clk_i), .base_valid_o(bv), .base_o(bp),
        .able_o(able), .next_valid_o(nv), .next_o(np), .rx_o(pr));
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One access plus an idle cycle, so strobes never rise twice in a step
    task automatic bus(input logic r, input logic [4:0] a, input logic [15:0] d);
        req = '{r, !r, a, d};
        @(posedge core_clk_i);
        #1 req = '0;
        got = rdata;
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic stop_test;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic t_reset;
        logic [4:0] a [7] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h10, 5'h11, 5'h1F};
        logic [15:0] e [7] = '{16'h0001, 16'h0004, 16'h2001, 16'h0000, 16'h0, 16'h0, 16'h0};
        chk(lp, 16'h2001);
        chk({15'h0000, pll}, 16'h0001);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, a[i], 16'h0000);
            chk(got, e[i]);
        end
        $display("reset values done");
    endtask
    task automatic t_pages;
        base_page_type p;
        next_page_type n;
        for (int i = 0; i < 4; i++) begin
            p = {i[0], 1'b1, i[1], 2'(i), 5'h15 >> i, 5'h01};
            n = {i[0], 1'b1, i[1], !i[1], 1'b0, 11'h5A5 ^ 11'(i)};
            fault = i[1];
            u_partner.send(p, i[1], n);
            fault = 1'b0;
            if (i[0]) bus(1'b1, 5'h05, 16'h0000);
            bus(1'b1, 5'h06, 16'h0000);
            chk(got, {11'h000, i[1], i[0], 2'b11, i[1]});
            bus(1'b1, 5'h06, 16'h0000);
            chk(got, {11'h000, 1'b0, i[0], 2'b10, i[1]});
            bus(1'b0, 5'h05, 16'hFFFF);
            bus(1'b1, 5'h05, 16'h0000);
            chk(got, {p[14:12], 1'b0, p[11:0]});
            bus(1'b1, 5'h08, 16'h0000);
            chk(got, {n[15:12], 1'b0, n[10:0]});
        end
        $display("partner pages done");
    endtask
    task automatic t_local;
        bus(1'b0, 5'h07, 16'hFFFF);
        for (int i = 0; i < 2; i++) begin
            sent = 1'b1;
            @(posedge core_clk_i);
            #1 sent = 1'b0;
            chk(lp, {4'hB, !i[0], 11'h7FF});
            bus(1'b1, 5'h07, 16'h0000);
            chk(got, {4'hB, i[0], 11'h7FF});
            bus(1'b1, 5'h08, 16'h0000);
            chk({15'h0000, got[11]}, {15'h0000, !i[0]});
        end
        bus(1'b0, 5'h07, 16'h0000);
        chk(lp, 16'h0000);
        bus(1'b0, 5'h10, 16'h0010);
        chk({15'h0000, pll}, 16'h0001);
        pd = 1'b1;
        #1 chk({15'h0000, pll}, 16'h0000);
        bus(1'b0, 5'h10, 16'h0000);
        #1 chk({15'h0000, pll}, 16'h0001);
        pd = 1'b0;
        bus(1'b0, 5'h11, 16'hFFFF);
        bus(1'b1, 5'h11, 16'h0000);
        chk(got, 16'hFFC0);
        $display("local page and pll done");
    endtask
    // Ten reset cycles, then the scenarios
    initial begin
        repeat (10) @(posedge core_clk_i);
        #1 reset_i = 1'b0;
        t_reset;
        t_pages;
        t_local;
        stop_test;
    end
endmodule
